// File: logic/wss_params.svh
// Register offsets, field positions, reset values and timing figures of the slot sequencer.
`ifndef WSS_PARAMS_SVH
`define WSS_PARAMS_SVH
`define WSS_SLOT_FIRST    8'h0F
`define WSS_SLOT_LAST     8'h16
`define WSS_SLOT_FOUR     8'h12
`define WSS_SLOT_FIVE     8'h13
`define WSS_MODE_BIT      7
`define WSS_FIELD_MSB     6
`define WSS_SLOT_RESET    8'h00
`define WSS_STOP_INDEX    7'h00
`define WSS_UNMAPPED_READ 8'h00
`define WSS_FIRST_SLOT    3'h0
`define WSS_LAST_SLOT     3'h7
`define WSS_PAUSE_STEP_MS 10
`define WSS_CLK_KHZ       10000
`endif

// File: logic/wss_pkg.sv
// Types shared by the slot sequencer files.
`include "wss_params.svh"
package wss_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } wss_bus_req_t;

  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_DECODE, S_PLAY, S_PAUSE} wss_state_t;
endpackage

// File: logic/wss_slot_mem.sv
// Eight-byte slot store with one write port and two registered read ports.
`timescale 1ns/100ps
`include "wss_params.svh"
module wss_slot_mem
  import wss_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             clk,      // Core clock.
  input  wire logic             resetn,   // Asynchronous reset, active low.
  input  wire logic             wr_en,    // Write strobe.
  input  wire logic [AW-1:0]    wr_addr,  // Write slot.
  input  wire logic [WIDTH-1:0] wr_data,  // Write data.
  input  wire logic             a_en,     // Bus read strobe.
  input  wire logic             a_hit,    // Bus read lands on a slot.
  input  wire logic [AW-1:0]    a_addr,   // Bus read slot.
  output logic      [WIDTH-1:0] a_data,   // Bus read data, one cycle later.
  input  wire logic             b_en,     // Sequencer read strobe.
  input  wire logic [AW-1:0]    b_addr,   // Sequencer read slot.
  output logic      [WIDTH-1:0] b_data    // Sequencer read data, one cycle later.
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [WIDTH-1:0] next_a_data;
  logic [WIDTH-1:0] next_b_data;

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      next_mem[i] = (wr_en && wr_addr == AW'(i)) ? wr_data : mem[i];
    end
    next_a_data = a_en ? (a_hit ? mem[a_addr] : WIDTH'(`WSS_UNMAPPED_READ)) : a_data;
    next_b_data = b_en ? mem[b_addr] : b_data;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= WIDTH'(`WSS_SLOT_RESET);
      end
      a_data <= WIDTH'(`WSS_UNMAPPED_READ);
      b_data <= WIDTH'(`WSS_SLOT_RESET);
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= next_mem[i];
      end
      a_data <= next_a_data;
      b_data <= next_b_data;
    end
  end
endmodule

// File: logic/wss_sequencer.sv
// Waveform slot sequencer: slot registers, playback walk and timed pauses.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`include "wss_params.svh"
// What this block does
// - Mode bit set: slot field is a pause, no waveform is played.
// - Pause lasts ten milliseconds times the unsigned seven-bit field.
// - Mode bit clear: field bits six to zero select the library waveform.
// - Start command begins playback at the lowest slot address.
// - After a slot finishes, the next higher slot is processed if nonzero.
// - Sequence ends at the first zero slot or after all eight slots.
// - Waveform index zero stops the sequencer.
// - Mode bit and field are read/write and reset to zero.
module wss_sequencer
  import wss_pkg::*;
#(
  parameter int TICK_CYCLES = `WSS_PAUSE_STEP_MS * `WSS_CLK_KHZ
) (
  input  wire logic         clk,          // Core clock, 10 MHz.
  input  wire logic         resetn,       // Asynchronous reset, active low.
  input  wire wss_bus_req_t bus,          // Register bus request.
  output logic        [7:0] rdata,        // Register read data, cycle after read.
  input  wire logic         start,        // Start command pulse.
  input  wire logic         slot_done,    // Playback engine finished a waveform.
  output logic        [6:0] play_index,   // Library waveform to play.
  output logic              play_strobe,  // One-cycle request to play play_index.
  output logic              seq_busy,     // Sequence in progress.
  output logic              pause_active, // Engine held idle by a pause slot.
  output logic              seq_end       // One-cycle pulse when a sequence ends.
);
  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic slot_hit(input logic [7:0] a);
    return (a >= `WSS_SLOT_FIRST) && (a <= `WSS_SLOT_LAST);
  endfunction

  function automatic logic [2:0] slot_of(input logic [7:0] a);
    logic [7:0] d;
    d = a - `WSS_SLOT_FIRST;
    return d[2:0];
  endfunction

  wss_state_t  state;
  wss_state_t  next_state;
  logic [2:0]  ptr;
  logic [2:0]  next_ptr;
  logic [6:0]  pause_left;
  logic [6:0]  next_pause_left;
  logic [6:0]  next_play_index;
  logic        next_play_strobe;
  logic        next_seq_busy;
  logic        next_pause_active;
  logic        next_seq_end;
  logic        seq_rd_en;
  logic [7:0]  seq_data;
  logic [31:0] tick_cnt;
  logic [31:0] next_tick_cnt;
  logic        tick;
  logic [6:0]  field;

  assign field = seq_data[`WSS_FIELD_MSB:0];

  wss_slot_mem #(.WIDTH(8), .DEPTH(8), .AW(3)) u_mem (
    .clk     (clk),
    .resetn  (resetn),
    .wr_en   (bus.wr && slot_hit(bus.addr)),
    .wr_addr (slot_of(bus.addr)),
    .wr_data (bus.wdata),
    .a_en    (bus.rd),
    .a_hit   (slot_hit(bus.addr)),
    .a_addr  (slot_of(bus.addr)),
    .a_data  (rdata),
    .b_en    (seq_rd_en),
    .b_addr  (ptr),
    .b_data  (seq_data)
  );

  // ****************************************************************
  // Pause tick
  // ****************************************************************
  // The counter only runs inside a pause so every pause starts on a whole step.
  assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

  always_comb begin
    next_tick_cnt = 32'h0;
    if (state == S_PAUSE && !tick) begin
      next_tick_cnt = tick_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  // ****************************************************************
  // Slot walk
  // ****************************************************************
  always_comb begin
    next_state        = state;
    next_ptr          = ptr;
    next_pause_left   = pause_left;
    next_play_index   = play_index;
    next_play_strobe  = 1'b0;
    next_seq_busy     = seq_busy;
    next_pause_active = pause_active;
    next_seq_end      = 1'b0;
    seq_rd_en         = 1'b0;
    unique case (state)
      S_IDLE: begin
        if (start) begin
          next_ptr      = `WSS_FIRST_SLOT;
          next_state    = S_FETCH;
          next_seq_busy = 1'b1;
        end
      end
      S_FETCH: begin
        seq_rd_en  = 1'b1;
        next_state = S_DECODE;
      end
      S_DECODE: begin
        if (seq_data[`WSS_MODE_BIT]) begin
          next_pause_left   = field;
          next_pause_active = 1'b1;
          next_state        = S_PAUSE;
        end else if (field == `WSS_STOP_INDEX) begin
          next_state    = S_IDLE;
          next_seq_busy = 1'b0;
          next_seq_end  = 1'b1;
        end else begin
          next_play_index  = field;
          next_play_strobe = 1'b1;
          next_state       = S_PLAY;
        end
      end
      S_PLAY, S_PAUSE: begin
        if (state == S_PAUSE && pause_left != 7'h00) begin
          if (tick) begin
            next_pause_left = pause_left - 7'h1;
          end
        end else if (state == S_PAUSE || slot_done) begin
          next_pause_active = 1'b0;
          if (ptr == `WSS_LAST_SLOT) begin
            next_state    = S_IDLE;
            next_seq_busy = 1'b0;
            next_seq_end  = 1'b1;
          end else begin
            next_ptr   = ptr + 3'h1;
            next_state = S_FETCH;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state        <= S_IDLE;
      ptr          <= `WSS_FIRST_SLOT;
      pause_left   <= 7'h00;
      play_index   <= 7'h00;
      play_strobe  <= 1'b0;
      seq_busy     <= 1'b0;
      pause_active <= 1'b0;
      seq_end      <= 1'b0;
    end else begin
      state        <= next_state;
      ptr          <= next_ptr;
      pause_left   <= next_pause_left;
      play_index   <= next_play_index;
      play_strobe  <= next_play_strobe;
      seq_busy     <= next_seq_busy;
      pause_active <= next_pause_active;
      seq_end      <= next_seq_end;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [31:0] pause_cyc;
  logic [6:0]  pause_len;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pause_cyc <= 32'h0;
      pause_len <= 7'h00;
    end else begin
      pause_cyc <= (state == S_PAUSE) ? pause_cyc + 32'h1 : 32'h0;
      if (state == S_DECODE) begin
        pause_len <= field;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence pause_slot_s;
    state == S_DECODE && seq_data[`WSS_MODE_BIT];
  endsequence

  sequence slot_write_s;
    bus.wr && slot_hit(bus.addr);
  endsequence

  pause_no_play_a: assert property (
    pause_slot_s |=> (state == S_PAUSE && pause_active && !play_strobe) ##1 !play_strobe)
    else $error("Pause slot started a waveform");

  pause_length_a: assert property (
    state == S_PAUSE && pause_left == 7'h00 |->
      pause_cyc == 32'(pause_len) * 32'(TICK_CYCLES))
    else $error("Pause length differs from field times step");

  index_play_a: assert property (
    state == S_DECODE && !seq_data[`WSS_MODE_BIT] && field != `WSS_STOP_INDEX |=>
      play_strobe && play_index == $past(field) && state == S_PLAY)
    else $error("Waveform index not presented");

  start_first_a: assert property (
    state == S_IDLE && start |=> state == S_FETCH && ptr == `WSS_FIRST_SLOT ##1
      state == S_DECODE)
    else $error("Start did not fetch the first slot");

  slot_advance_a: assert property (
    state == S_PLAY && slot_done && ptr != `WSS_LAST_SLOT |=>
      state == S_FETCH && ptr == $past(ptr) + 3'h1)
    else $error("Sequencer did not advance to next slot");

  last_slot_end_a: assert property (
    state == S_PLAY && slot_done && ptr == `WSS_LAST_SLOT |=>
      state == S_IDLE && seq_end && !seq_busy)
    else $error("Sequence did not end after last slot");

  stop_index_a: assert property (
    state == S_DECODE && seq_data == 8'h00 |=> seq_end && state == S_IDLE ##1 !seq_end)
    else $error("Zero index did not stop the sequencer");

  slot_readback_a: assert property (
    slot_write_s ##1 bus.rd && $past(bus.addr) == bus.addr && !bus.wr |=>
      rdata == $past(bus.wdata, 2))
    else $error("Slot readback differs from written value");

  tick_period_a: assert property (
    tick |=> tick_cnt == 32'h0 && !tick)
    else $error("Tick counter did not wrap after a step");
endmodule

// File: testbench/wss_testbench.sv
// Self-checking testbench for the waveform slot sequencer.
`timescale 1ns/100ps
`include "wss_params.svh"
module testbench;
  import wss_pkg::*;
  localparam int TICK = 4;
  logic         clk;
  logic         resetn;
  wss_bus_req_t bus;
  logic   [7:0] rdata;
  logic         start;
  logic         slot_done;
  logic   [6:0] play_index;
  logic         play_strobe;
  logic         seq_busy;
  logic         pause_active;
  logic         seq_end;
  int           n_fail = 0;
  int           n_checks = 0;
  int           cycles = 0;
  logic   [7:0] slots [8];

  wss_sequencer #(.TICK_CYCLES(TICK)) dut (
    .clk          (clk),
    .resetn       (resetn),
    .bus          (bus),
    .rdata        (rdata),
    .start        (start),
    .slot_done    (slot_done),
    .play_index   (play_index),
    .play_strobe  (play_strobe),
    .seq_busy     (seq_busy),
    .pause_active (pause_active),
    .seq_end      (seq_end)
  );

  always #50 clk = ~clk;

  // **********
  // Reporting
  // **********
  task automatic end_sim();
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // A walk of eight long pauses stays far below this ceiling.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // **********
  // Bus and sequencer drivers
  // **********
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge clk);
    bus.wr <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
    @(posedge clk);
    bus.rd <= 1'h0;
    @(negedge clk);
    d = rdata;
  endtask

  // Looks at the current falling edge first, so an event already showing is not missed.
  task automatic wait_evt(output int n);
    n = 0;
    while (!(play_strobe || pause_active || seq_end) && n < 1000) begin
      @(negedge clk);
      n++;
    end
  endtask

  // Every wait starts at the first falling edge after the start or a slot ends, so each latency is two cycles, or zero once the eighth slot has ended.
  task automatic run_seq();
    int n;
    int i;
    int cnt;
    @(posedge clk);
    start <= 1'h1;
    @(posedge clk);
    start <= 1'h0;
    @(negedge clk);
    for (i = 0; i < 8 && slots[i] != 8'h00; i++) begin
      wait_evt(n);
      chk(16'(n), 16'h2);
      chk({play_strobe, pause_active, seq_end}, slots[i][7] ? 3'h2 : 3'h4);
      if (slots[i][7]) begin
        chk(seq_busy, 1'h1);
        cnt = 0;
        while (pause_active && cnt < 1000) begin
          cnt++;
          @(negedge clk);
        end
        chk(16'(cnt), 16'(slots[i][6:0] * TICK + 1));
      end else begin
        chk(play_index, slots[i][6:0]);
        repeat ($urandom_range(0, 3)) @(posedge clk);
        @(posedge clk);
        start <= 1'h1;
        slot_done <= 1'h1;
        @(posedge clk);
        start <= 1'h0;
        slot_done <= 1'h0;
        @(negedge clk);
      end
    end
    wait_evt(n);
    chk(16'(n), (i < 8) ? 16'h2 : 16'h0);
    chk({play_strobe, pause_active, seq_end}, 3'h1);
    @(negedge clk);
    chk({seq_busy, seq_end}, 2'h0);
  endtask

  // **********
  // Main sequence
  // **********
  initial begin
    logic [7:0] d;
    int         k;
    int         i;
    clk = 1'h0;
    resetn = 1'h0;
    bus = '0;
    start = 1'h0;
    slot_done = 1'h0;
    void'($urandom(24));
    repeat (20) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    slot_done <= 1'h1;
    @(posedge clk);
    slot_done <= 1'h0;
    for (i = 8'h0E; i <= 8'h17; i++) begin
      rd(8'(i), d);
      chk(d, `WSS_SLOT_RESET);
    end
    chk({seq_busy, play_strobe}, 2'h0);
    wr(8'h17, 8'hFF);
    rd(8'h17, d);
    chk(d, `WSS_UNMAPPED_READ);
    rd(`WSS_SLOT_FIRST, d);
    chk(d, `WSS_SLOT_RESET);
    // Write and read of one slot with no idle cycle between the strobes.
    @(posedge clk);
    bus <= '{addr: `WSS_SLOT_FOUR, wdata: 8'h85, wr: 1'h1, rd: 1'h0};
    @(posedge clk);
    bus <= '{addr: `WSS_SLOT_FOUR, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
    @(posedge clk);
    bus.rd <= 1'h0;
    @(negedge clk);
    chk(rdata, 8'h85);
    for (k = 0; k < 4; k++) begin
      for (i = 0; i < 8; i++) begin
        slots[i] = $urandom_range(0, 1) ? {1'h1, 7'($urandom_range(0, 3))}
                                        : {1'h0, 7'($urandom_range(1, 127))};
      end
      if (k == 1) slots[2] = 8'h00;
      if (k == 2) slots[3] = 8'h80;
      if (k == 3) slots[0] = 8'h00;
      for (i = 0; i < 8; i++) wr(`WSS_SLOT_FIRST + 8'(i), slots[i]);
      rd(`WSS_SLOT_FOUR, d);
      chk(d, slots[3]);
      rd(`WSS_SLOT_FIVE, d);
      chk(d, slots[4]);
      run_seq();
    end
    end_sim();
  end
endmodule
